// [tdmpk_defines.svh]
/*
  Offsets, field positions, reset values and limits of the TDM packetizer.
  Assumes one 10 MHz clock and byte addresses on a 32-bit AXI4-Lite bus.
*/
// Behaviour
// R1: Unstructured payload length 64 to 1514 octets, multiple of 32, else rejected.
// R2: Unstructured default length 192 octets DS1, 256 octets E1, 1.00 ms.
// R3: DS1 unstructured packs framing bit 193 with channel bits into payload.
// R4: Extended superframe data link bits ride transparently in unstructured payload.
// R5: Unstructured mode puts all 24 or 32 timeslots into the group.
// R6: Unstructured ignores framing; line must be set unframed first.
// R7: Structured group holds 1 to 24 slots on DS1, 1 to 31 on E1.
// R8: Structured without signaling: length is whole multiple of timeslot count.
// R9: Structured payload length at most 1514 octets.
// R10: Smallest structured packet is two frames, 0.250 ms delay.
// R11: Each frame adds one octet per member slot; members may be scattered.
// R12: Structured length equals slot count times frames per packet.
// R13: Frames arrive every 125 us; delay is frames times that period.
// R14: Default frames per packet 64, 32, 16 or 8 by slot count.
// R15: With signaling, frames per packet fixed at 24 on T1, 16 on E1.
// R16: Signaling octets appended beyond the configured payload length.
// R17: Software sets maximum packet length to cover payload plus signaling.
// R18: Structured transport needs a framed line setting.
// R19: Signaling adds n/2 octets for even n, (n+1)/2 for odd.
// R20: E1 with signaling excludes timeslot 16 from every group.
// R21: Constraint violations flag a configuration error and hold service down.
`ifndef TDMPK_DEFINES_SVH
`define TDMPK_DEFINES_SVH
`define TDMPK_ADR_CTRL   8'h00
`define TDMPK_ADR_PLEN   8'h04
`define TDMPK_ADR_MASK   8'h08
`define TDMPK_ADR_MTU    8'h0C
`define TDMPK_ADR_STAT   8'h10
`define TDMPK_ADR_INFO   8'h14
`define TDMPK_ADR_FPP    8'h18
`define TDMPK_C_EN       0
`define TDMPK_C_E1       1
`define TDMPK_C_STR      2
`define TDMPK_C_CAS      3
`define TDMPK_C_DFLT     4
`define TDMPK_C_UNFR     5
`define TDMPK_S_OVR      2
`define TDMPK_RST_CTRL   32'h00000030
`define TDMPK_RST_PLEN   11'h0C0
`define TDMPK_RST_MASK   32'h00000000
`define TDMPK_RST_MTU    11'h5EA
`define TDMPK_LEN_MIN    11'h040
`define TDMPK_LEN_MAX    11'h5EA
`define TDMPK_DFLT_T1    11'h0C0
`define TDMPK_DFLT_E1    11'h100
`define TDMPK_N_T1       6'h18
`define TDMPK_N_E1       6'h20
`define TDMPK_NMAX_E1    6'h1F
`define TDMPK_CASF_T1    7'h18
`define TDMPK_CASF_E1    7'h10
`define TDMPK_FPP_N1     7'h40
`define TDMPK_FPP_N4     7'h20
`define TDMPK_FPP_N15    7'h10
`define TDMPK_FPP_N16    7'h08
`define TDMPK_E1_SIG_TS  16
`define TDMPK_FRAME_US   16'h007D
`endif

// [tdmpk_pkg.sv]
/*
  Types of the TDM packetizer: line strobe, packet octet, state.
  Assumes the line framer sits on the same clock as the packetizer.
*/
package tdmpk_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SIG} tdmpk_state_e;
  typedef struct packed {
    logic       frame_start;
    logic       fbit;
    logic       ts_valid;
    logic [4:0] index;
    logic [7:0] octet;
    logic [3:0] abcd;
  } tdmpk_line_s;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       sig;
    logic [7:0] data;
  } tdmpk_pkt_s;
endpackage

// [tdmpk_packetizer.sv]
/*
  TDM circuit emulation packetizer: config checks, octet packing, signaling.
  Assumes line strobes from same-clock framer logic and AXI4-Lite software.
*/
`timescale 1ns/1ns
`include "tdmpk_defines.svh"
module tdmpk_packetizer (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic [7:0]          i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [7:0]          i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  input  wire tdmpk_pkg::tdmpk_line_s i_line,
  output tdmpk_pkg::tdmpk_pkt_s    o_pkt,
  output logic                     o_oper,
  output logic                     o_cfg_err
);
  import tdmpk_pkg::*;

  function automatic logic [5:0] f_count(input logic [31:0] m);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) c = c + {5'h00, m[i]};
    return c;
  endfunction

  function automatic logic [6:0] f_fpp(input logic [5:0] n);
    if (n == 6'h01) return `TDMPK_FPP_N1;
    else if (n <= 6'h04) return `TDMPK_FPP_N4;
    else if (n <= 6'h0F) return `TDMPK_FPP_N15;
    return `TDMPK_FPP_N16;
  endfunction

  function automatic logic [31:0] f_strb(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    return r;
  endfunction

  logic [31:0]  ctrl_reg;
  logic [31:0]  mask_reg;
  logic [10:0]  plen_reg;
  logic [10:0]  mtu_reg;
  logic         ovr_reg;
  logic         awrdy_reg, wrdy_reg, bvalid_reg, arrdy_reg, rvalid_reg;
  logic [1:0]   bresp_reg, rresp_reg;
  logic [31:0]  rdata_reg, wdata_reg, rd_w;
  logic [7:0]   awaddr_reg;
  logic [3:0]   wstrb_reg;
  logic         rd_hit_w;
  tdmpk_state_e st_reg;
  logic [7:0]   pk_acc_reg;
  logic [2:0]   pk_cnt_reg;
  logic [10:0]  pay_cnt_reg;
  logic [6:0]   fcnt_reg, last_fpp_reg;
  logic [5:0]   mcnt_reg;
  logic [3:0]   hold_reg;
  logic [4:0]   sig_idx_reg;
  logic [7:0]   sig_buf [0:15];
  tdmpk_pkt_s   pkt_reg;
  logic         oper_reg, err_reg;

  // Configuration decode
  wire en_w   = ctrl_reg[`TDMPK_C_EN];
  wire e1_w   = ctrl_reg[`TDMPK_C_E1];
  wire strc_w = ctrl_reg[`TDMPK_C_STR];
  wire cas_w  = ctrl_reg[`TDMPK_C_CAS] & strc_w;
  wire dflt_w = ctrl_reg[`TDMPK_C_DFLT];
  wire unfr_w = ctrl_reg[`TDMPK_C_UNFR];
  wire [31:0] all_w  = e1_w ? 32'hFFFFFFFF : 32'h00FFFFFF;
  wire [31:0] memb_w = strc_w ? (mask_reg & all_w) : all_w; // R5 R11
  wire [5:0]  n_w    = f_count(memb_w);
  wire [6:0]  fcas_w = e1_w ? `TDMPK_CASF_E1 : `TDMPK_CASF_T1; // R15
  wire [6:0]  fsel_w = cas_w ? fcas_w : f_fpp(n_w); // R14
  // Widen before the product so 16 x 8 and up do not wrap
  wire [10:0] lstr_w = (cas_w | dflt_w) ? {5'h00, n_w} * {4'h0, fsel_w}
                                        : plen_reg; // R12
  wire [10:0] lun_w  = !dflt_w ? plen_reg
                     : e1_w ? `TDMPK_DFLT_E1 : `TDMPK_DFLT_T1; // R2
  wire [10:0] len_w  = strc_w ? lstr_w : lun_w;
  wire [10:0] rem_w  = (n_w == 6'h00) ? 11'h000
                     : len_w % {5'h00, n_w};
  wire [4:0]  sigo_w = cas_w ? 5'((n_w + 6'h01) >> 1) : 5'h00; // R19
  wire [11:0] tot_w  = {1'b0, len_w} + {7'h00, sigo_w}; // R16
  wire [5:0]  nmax_w = e1_w ? `TDMPK_NMAX_E1 : `TDMPK_N_T1;
  wire err_un_w = len_w < `TDMPK_LEN_MIN || len_w > `TDMPK_LEN_MAX
                || len_w[4:0] != 5'h00 // R1
                || !unfr_w; // R6
  wire err_st_w = n_w == 6'h00 || n_w > nmax_w // R7
                || (!cas_w && rem_w != 11'h000) // R8
                || len_w > `TDMPK_LEN_MAX // R9
                || len_w < {4'h0, n_w, 1'b0} // R10
                || unfr_w // R18
                || (e1_w && cas_w && mask_reg[`TDMPK_E1_SIG_TS]); // R20
  // Too small a limit means the packet can never leave whole
  wire err_w = (strc_w ? err_st_w : err_un_w)
             || {1'b0, mtu_reg} < tot_w; // R21
  wire op_w  = en_w && !err_w; // R21

  // Line side decode
  wire acc_w  = op_w && (st_reg == ST_RUN
              || (st_reg == ST_IDLE && i_line.frame_start));
  wire memb_in_w = i_line.ts_valid && memb_w[i_line.index];
  wire tbit_w = acc_w && i_line.frame_start && !strc_w && !e1_w; // R3 R4
  wire toct_w = acc_w && memb_in_w && !i_line.frame_start; // R11
  wire [15:0] wide_w = {pk_acc_reg, i_line.octet};
  wire [7:0]  bitb_w = {pk_acc_reg[6:0], i_line.fbit};
  wire [3:0]  ncnt_w = {1'b0, pk_cnt_reg}
                     + (toct_w ? 4'h8 : tbit_w ? 4'h1 : 4'h0);
  wire emit_w = ncnt_w[3];
  wire [7:0]  byte_w = toct_w ? 8'(wide_w >> pk_cnt_reg) : bitb_w;
  wire plast_w = emit_w && (pay_cnt_reg + 11'h001 == len_w);
  wire slast_w = sig_idx_reg + 5'h01 == sigo_w;
  wire ovr_set_w = i_ce && st_reg == ST_SIG
                 && (memb_in_w || i_line.frame_start);

  // Register bus decode
  wire wr_w    = i_ce && !awrdy_reg && !wrdy_reg && !bvalid_reg;
  wire wr_ctrl = wr_w && awaddr_reg == `TDMPK_ADR_CTRL;
  wire wr_plen = wr_w && awaddr_reg == `TDMPK_ADR_PLEN;
  wire wr_mask = wr_w && awaddr_reg == `TDMPK_ADR_MASK;
  wire wr_mtu  = wr_w && awaddr_reg == `TDMPK_ADR_MTU;
  wire wr_stat = wr_w && awaddr_reg == `TDMPK_ADR_STAT;
  wire wr_hit  = wr_ctrl | wr_plen | wr_mask | wr_mtu | wr_stat;
  wire ovr_clr_w = wr_stat && wstrb_reg[0]
                 && wdata_reg[`TDMPK_S_OVR];
  wire [31:0] wnew_w = f_strb(32'h00000000, wdata_reg, wstrb_reg);

  always_comb begin
    rd_w = 32'h00000000;
    rd_hit_w = 1'b1;
    if (i_araddr == `TDMPK_ADR_CTRL) rd_w = ctrl_reg;
    else if (i_araddr == `TDMPK_ADR_PLEN) rd_w = {21'h0, plen_reg};
    else if (i_araddr == `TDMPK_ADR_MASK) rd_w = mask_reg;
    else if (i_araddr == `TDMPK_ADR_MTU) rd_w = {21'h0, mtu_reg};
    else if (i_araddr == `TDMPK_ADR_STAT)
      rd_w = {29'h0, ovr_reg, err_reg, oper_reg};
    else if (i_araddr == `TDMPK_ADR_INFO)
      rd_w = {2'h0, n_w, 3'h0, sigo_w, 5'h0, len_w};
    else if (i_araddr == `TDMPK_ADR_FPP) // R13
      rd_w = {16'(last_fpp_reg * `TDMPK_FRAME_US), 9'h0, last_fpp_reg};
    else rd_hit_w = 1'b0;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      awrdy_reg  <= 1'b1;
      wrdy_reg   <= 1'b1;
      arrdy_reg  <= 1'b1;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h00000000;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      ctrl_reg   <= `TDMPK_RST_CTRL;
      plen_reg   <= `TDMPK_RST_PLEN;
      mask_reg   <= `TDMPK_RST_MASK;
      mtu_reg    <= `TDMPK_RST_MTU;
    end else if (i_ce) begin
      if (awrdy_reg && i_awvalid) begin
        awaddr_reg <= i_awaddr;
        awrdy_reg  <= 1'b0;
      end
      if (wrdy_reg && i_wvalid) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
        wrdy_reg  <= 1'b0;
      end
      if (wr_w) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? 2'h0 : 2'h2;
      end
      if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
        awrdy_reg  <= 1'b1;
        wrdy_reg   <= 1'b1;
      end
      if (wr_ctrl) ctrl_reg <= f_strb(ctrl_reg, wdata_reg, wstrb_reg);
      if (wr_mask) mask_reg <= f_strb(mask_reg, wdata_reg, wstrb_reg);
      if (wr_plen) plen_reg <= wnew_w[10:0];
      if (wr_mtu) mtu_reg <= wnew_w[10:0];
      if (arrdy_reg && i_arvalid) begin
        rdata_reg  <= rd_w;
        rresp_reg  <= rd_hit_w ? 2'h0 : 2'h2;
        rvalid_reg <= 1'b1;
        arrdy_reg  <= 1'b0;
      end
      if (rvalid_reg && i_rready) begin
        rvalid_reg <= 1'b0;
        arrdy_reg  <= 1'b1;
      end
    end
  end

  // Line side: packing, packet framing and signaling append
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg       <= ST_IDLE;
      pk_acc_reg   <= 8'h00;
      pk_cnt_reg   <= 3'h0;
      pay_cnt_reg  <= 11'h000;
      fcnt_reg     <= 7'h00;
      last_fpp_reg <= 7'h00;
      mcnt_reg     <= 6'h00;
      hold_reg     <= 4'h0;
      sig_idx_reg  <= 5'h00;
      pkt_reg      <= '0;
      ovr_reg      <= 1'b0;
      oper_reg     <= 1'b0;
      err_reg      <= 1'b0;
    end else if (i_ce) begin
      oper_reg <= op_w;
      err_reg  <= err_w;
      pkt_reg  <= '0;
      // Set wins so an overrun in the clearing cycle is kept
      if (ovr_set_w) ovr_reg <= 1'b1;
      else if (ovr_clr_w) ovr_reg <= 1'b0;
      if (tbit_w || toct_w) begin
        pk_acc_reg <= toct_w ? i_line.octet : bitb_w;
        pk_cnt_reg <= ncnt_w[2:0];
      end
      if (acc_w && i_line.frame_start) begin
        fcnt_reg <= fcnt_reg + 7'h01; // R13
        mcnt_reg <= 6'h00;
      end
      if (toct_w && cas_w) begin
        mcnt_reg <= mcnt_reg + 6'h01;
        if (mcnt_reg[0])
          sig_buf[mcnt_reg[4:1]] <= {hold_reg, i_line.abcd};
        else if (mcnt_reg + 6'h01 == n_w) // R19
          sig_buf[mcnt_reg[4:1]] <= {i_line.abcd, 4'h0};
        else
          hold_reg <= i_line.abcd;
      end
      if (emit_w) begin
        pkt_reg.valid <= 1'b1;
        pkt_reg.last  <= plast_w && sigo_w == 5'h00;
        pkt_reg.data  <= byte_w;
        pay_cnt_reg   <= plast_w ? 11'h000 : pay_cnt_reg + 11'h001;
      end
      if (plast_w) begin
        last_fpp_reg <= fcnt_reg; // R13
        fcnt_reg     <= 7'h00;
      end
      if (!op_w) begin
        st_reg      <= ST_IDLE;
        pk_cnt_reg  <= 3'h0;
        pay_cnt_reg <= 11'h000;
        fcnt_reg    <= 7'h00;
        sig_idx_reg <= 5'h00;
      end else begin
        case (st_reg)
          ST_IDLE: begin
            if (i_line.frame_start) st_reg <= ST_RUN;
          end
          ST_RUN: begin
            if (plast_w && sigo_w != 5'h00) st_reg <= ST_SIG; // R16
          end
          ST_SIG: begin
            // Line strobes here are dropped; framer must leave a gap
            pkt_reg.valid <= 1'b1;
            pkt_reg.sig   <= 1'b1;
            pkt_reg.last  <= slast_w;
            pkt_reg.data  <= sig_buf[sig_idx_reg[3:0]];
            sig_idx_reg   <= slast_w ? 5'h00 : sig_idx_reg + 5'h01;
            if (slast_w) st_reg <= ST_RUN; // R19
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign o_awready = awrdy_reg;
  assign o_wready  = wrdy_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_arready = arrdy_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rresp   = rresp_reg;
  assign o_rdata   = rdata_reg;
  assign o_pkt     = pkt_reg;
  assign o_oper    = oper_reg;
  assign o_cfg_err = err_reg;

  // Checks
  logic [10:0] chk_pay_reg;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) chk_pay_reg <= 11'h000;
    // Signaling octets close a packet but are not payload
    else if (i_ce && o_pkt.valid && o_pkt.last) chk_pay_reg <= 11'h000;
    else if (i_ce && o_pkt.valid && !o_pkt.sig)
      chk_pay_reg <= chk_pay_reg + 11'h001;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_un_len;
    op_w && !strc_w |-> len_w >= 11'd64 && len_w <= 11'd1514
      && len_w[4:0] == 5'h00;
  endproperty
  a_un_len: assert property (p_un_len) else $error("bad length"); // R1
  property p_dflt;
    !strc_w && dflt_w |-> len_w == (e1_w ? 11'd256 : 11'd192);
  endproperty
  a_dflt: assert property (p_dflt) else $error("bad default"); // R2
  property p_fbit;
    i_ce && tbit_w |=> pk_cnt_reg == 3'($past(pk_cnt_reg) + 3'h1);
  endproperty
  a_fbit: assert property (p_fbit) else $error("fbit lost"); // R3
  property p_all_ts;
    !strc_w |-> n_w == (e1_w ? 6'd32 : 6'd24);
  endproperty
  a_all_ts: assert property (p_all_ts) else $error("slot count"); // R5
  property p_str_n;
    op_w && strc_w |-> n_w >= 6'd1 && n_w <= (e1_w ? 6'd31 : 6'd24)
      && rem_w == 11'h000 && len_w >= 11'(2 * n_w);
  endproperty
  a_str_n: assert property (p_str_n) else $error("str cfg"); // R7
  property p_cas_len;
    op_w && cas_w |-> len_w == {5'h00, n_w} * (e1_w ? 11'd16 : 11'd24)
      && !(e1_w && memb_w[16]);
  endproperty
  a_cas_len: assert property (p_cas_len) else $error("cas len"); // R15
  property p_sig_go;
    i_ce && op_w && st_reg == ST_RUN && plast_w && sigo_w != 5'h00
      |=> st_reg == ST_SIG ##1 o_pkt.valid && o_pkt.sig;
  endproperty
  a_sig_go: assert property (p_sig_go) else $error("no sig"); // R16
  property p_pay_cnt;
    o_pkt.valid && o_pkt.last |->
      (o_pkt.sig ? chk_pay_reg : chk_pay_reg + 11'h001) == len_w;
  endproperty
  a_pay_cnt: assert property (p_pay_cnt) else $error("len"); // R12
  property p_down;
    i_ce && !op_w |=> !o_pkt.valid && st_reg == ST_IDLE;
  endproperty
  a_down: assert property (p_down) else $error("ran bad cfg"); // R21
  c_un_pkt: cover property (o_pkt.last && !strc_w);
  c_sig_pkt: cover property (o_pkt.last && o_pkt.sig);
  c_err: cover property (o_cfg_err ##1 !o_cfg_err);
endmodule

// [tdmpk_pw_peer.sv]
/*
  Far-end pseudowire sink: counts packet octets, keeps a packet's head.
  Assumes one octet a cycle on the packetizer clock, no back-pressure.
*/
`timescale 1ns/1ns
module tdmpk_pw_peer (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire tdmpk_pkg::tdmpk_pkt_s i_pkt,
  output logic [10:0]               o_len,
  output logic [31:0]               o_head,
  output logic [15:0]               o_pkts
);
  import tdmpk_pkg::*;
  logic [10:0] cnt_reg;
  // A packet ends only on last; signaling octets count too
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 11'h000;
      o_len   <= 11'h000;
      o_head  <= 32'h00000000;
      o_pkts  <= 16'h0000;
    end else if (i_pkt.valid) begin
      cnt_reg <= i_pkt.last ? 11'h000 : cnt_reg + 11'h001;
      if (cnt_reg < 11'h004) o_head <= {o_head[23:0], i_pkt.data};
      if (i_pkt.last) o_len <= cnt_reg + 11'h001;
      if (i_pkt.last) o_pkts <= o_pkts + 16'h0001;
    end
  end
endmodule

// [tdm_circuit_emulation_packetizer_bench.sv]
/*
  Bench of the TDM packetizer: register bus, config checks, line traffic.
  Assumes the defines header and the pseudowire sink model.
*/
`timescale 1ns/1ns
`include "tdmpk_defines.svh"
module tdm_circuit_emulation_packetizer_bench;
  import tdmpk_pkg::*;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, oper, cfg_err;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, head;
  logic [1:0]  bresp, rresp;
  logic [10:0] len;
  logic [15:0] pkts;
  tdmpk_line_s ln;
  tdmpk_pkt_s  pkt;
  int          err_total, total_checks;
  tdmpk_packetizer dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_line(ln), .o_pkt(pkt), .o_oper(oper), .o_cfg_err(cfg_err));
  tdmpk_pw_peer peer (.i_ref_clk(clk), .i_rst(rst), .i_pkt(pkt),
    .o_len(len), .o_head(head), .o_pkts(pkts));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic hang(input logic ok);
    if (!ok) begin
      err_total++;
      close_out();
    end
  endtask
  // Address and data offered together; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] br);
    int   k;
    logic done;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    done = 1'b0;
    br = 2'h3;
    // Each channel released at the edge that takes it
    while (!done && k < 60) begin
      @(posedge clk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        br = bresp;
        done = 1'b1;
      end
    end
    hang(done);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!arready && k < 60);
    hang(arready);
    arvalid <= 1'b0;
    k = 0;
    while (!rvalid && k < 60) begin
      @(posedge clk);
      k++;
    end
    hang(rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Disable first: checks are live while enabled
  task automatic cfg(input logic [7:0] c, input logic [10:0] p,
                     input logic [31:0] m, input logic [10:0] u);
    logic [1:0] b;
    wr(`TDMPK_ADR_CTRL, 32'h00000000, b);
    wr(`TDMPK_ADR_PLEN, {21'h000000, p}, b);
    wr(`TDMPK_ADR_MASK, m, b);
    wr(`TDMPK_ADR_MTU, {21'h000000, u}, b);
    wr(`TDMPK_ADR_CTRL, {24'h000000, c}, b);
    repeat (3) @(posedge clk);
  endtask
  task automatic st(input logic [7:0] c, input logic [10:0] p,
                    input logic [31:0] m, input logic [10:0] u,
                    input logic [1:0] e);
    cfg(c, p, m, u);
    chk({30'h00000000, oper, cfg_err}, {30'h00000000, e});
  endtask
  task automatic inf(input logic [7:0] c, input logic [10:0] p,
                     input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    cfg(c, p, m, 11'h5EA);
    rd(`TDMPK_ADR_INFO, d, r);
    chk(d, e);
  endtask
  // Compressed frame: strobes every other cycle, far faster than 125 us
  task automatic frame(input int ns, input logic fb, input logic idx);
    @(posedge clk);
    ln.frame_start <= 1'b1;
    ln.fbit <= fb;
    @(posedge clk);
    ln.frame_start <= 1'b0;
    for (int t = 0; t < ns; t++) begin
      @(posedge clk);
      ln.ts_valid <= 1'b1;
      ln.index <= t[4:0];
      ln.octet <= idx ? t[7:0] : 8'h00;
      @(posedge clk);
      ln.ts_valid <= 1'b0;
    end
  endtask
  task automatic s_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`TDMPK_ADR_CTRL, d, r);
    chk(d, `TDMPK_RST_CTRL);
    rd(`TDMPK_ADR_PLEN, d, r);
    chk(d, 32'h000000C0);
    rd(`TDMPK_ADR_INFO, d, r);
    chk(d, 32'h180000C0);
    rd(8'h1C, d, r);
    chk(d, 32'h00000000);
    chk({30'h00000000, r}, 32'h00000002);
    wr(8'h1C, 32'h00000001, r);
    chk({30'h00000000, r}, 32'h00000002);
  endtask
  task automatic s_limits();
    st(8'h21, 11'd48, 32'h0, 11'h5EA, 2'b01);
    st(8'h21, 11'd64, 32'h0, 11'h5EA, 2'b10);
    st(8'h21, 11'd100, 32'h0, 11'h5EA, 2'b01);
    st(8'h21, 11'd1504, 32'h0, 11'h5EA, 2'b10);
    st(8'h21, 11'd1514, 32'h0, 11'h5EA, 2'b01);
    st(8'h01, 11'd64, 32'h0, 11'h5EA, 2'b01);
    st(8'h05, 11'd5, 32'h208, 11'h5EA, 2'b01);
    st(8'h25, 11'd4, 32'h208, 11'h5EA, 2'b01);
    st(8'h05, 11'd1514, 32'h208, 11'h5EA, 2'b10);
    st(8'h05, 11'd1516, 32'h208, 11'h5EA, 2'b01);
    st(8'h05, 11'd1, 32'h8, 11'h5EA, 2'b01);
    st(8'h05, 11'd4, 32'h0, 11'h5EA, 2'b01);
    st(8'h05, 11'd50, 32'h1FFFFFF, 11'h5EA, 2'b01);
    st(8'h07, 11'd62, 32'hFFFFFFFE, 11'h5EA, 2'b10);
    st(8'h07, 11'd64, 32'hFFFFFFFF, 11'h5EA, 2'b01);
    st(8'h0F, 11'd48, 32'hE, 11'd49, 2'b01);
    st(8'h0F, 11'd48, 32'hE, 11'd50, 2'b10);
    st(8'h0F, 11'd48, 32'h1000E, 11'h5EA, 2'b01);
  endtask
  task automatic s_stream();
    logic [31:0] d;
    logic [1:0]  r;
    st(8'h05, 11'd2, 32'h8, 11'h5EA, 2'b10);
    st(8'h05, 11'd4, 32'h208, 11'h5EA, 2'b10);
    frame(24, 1'b0, 1'b1);
    frame(24, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk(head, 32'h03090309);
    chk({21'h0, len}, 32'h4);
    chk({16'h0, pkts}, 32'h1);
    rd(`TDMPK_ADR_FPP, d, r);
    chk(d, 32'h00FA0002);
  endtask
  task automatic s_unstr();
    st(8'h31, 11'd64, 32'h0, 11'h5EA, 2'b10);
    // 7 x 193 bits plus 185 bits: exactly one packet, no tail
    repeat (7) frame(24, 1'b1, 1'b0);
    frame(23, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk(head, 32'h80000000);
    chk({21'h0, len}, 32'd192);
    chk({16'h0, pkts}, 32'h2);
    inf(8'h33, 11'd64, 32'h0, 32'h20000100);
  endtask
  // DS1 signaling, slots 1..3: 24 frames, two appended octets
  task automatic s_cas();
    logic [31:0] d;
    logic [1:0]  r;
    st(8'h0D, 11'd72, 32'hE, 11'h5EA, 2'b10);
    ln.abcd <= 4'h5;
    repeat (24) frame(24, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk(head, 32'h01020301);
    chk({21'h0, len}, 32'd74);
    chk({16'h0, pkts}, 32'h3);
    rd(`TDMPK_ADR_FPP, d, r);
    chk(d, 32'h0BB80018);
    rd(`TDMPK_ADR_STAT, d, r);
    chk(d, 32'h00000001);
  endtask
  task automatic s_info();
    inf(8'h15, 11'd4, 32'h1, 32'h01000040);
    inf(8'h15, 11'd4, 32'h3, 32'h02000040);
    inf(8'h15, 11'd4, 32'h1F, 32'h05000050);
    inf(8'h15, 11'd4, 32'hFFFF, 32'h10000080);
    inf(8'h15, 11'd4, 32'hFFFFFF, 32'h180000C0);
    inf(8'h0F, 11'd48, 32'hE, 32'h03020030);
    inf(8'h0D, 11'd96, 32'hF, 32'h04020060);
  endtask
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    ln = '0;
    err_total = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_limits();
    s_stream();
    s_unstr();
    s_cas();
    s_info();
    close_out();
  end
endmodule
